// ===== hdl/t0co_consts.vh
`ifndef T0CO_CONSTS_VH
`define T0CO_CONSTS_VH

// Register offsets on the plain register port
`define T0CO_ADDR_CTRL 8'h1b
`define T0CO_ADDR_AUX 8'h1c
`define T0CO_ADDR_CMPA 8'h1d
`define T0CO_ADDR_CMPB 8'h1e
`define T0CO_ADDR_STAT 8'h1f

// Control register field positions
`define T0CO_COMA_HI 7
`define T0CO_COMA_LO 6
`define T0CO_COMB_HI 5
`define T0CO_COMB_LO 4
`define T0CO_WGM_HI 1
`define T0CO_WGM_LO 0
`define T0CO_CTRL_WMASK 8'hf3

// Auxiliary control field positions
`define T0CO_AUX_TOPSEL 0

// Status register field positions
`define T0CO_STAT_OCA 0
`define T0CO_STAT_OCB 1
`define T0CO_STAT_OVA 2
`define T0CO_STAT_OVB 3

// Reset values
`define T0CO_CTRL_RST 8'h00
`define T0CO_AUX_RST 8'h00
`define T0CO_CMP_RST 8'h00

// Waveform mode codes
`define T0CO_WGM_NORMAL 3'h0
`define T0CO_WGM_PC_FF 3'h1
`define T0CO_WGM_CTC 3'h2
`define T0CO_WGM_FAST_FF 3'h3
`define T0CO_WGM_PC_A 3'h5
`define T0CO_WGM_FAST_A 3'h7

// Counter limits
`define T0CO_MAX 8'hff
`define T0CO_BOTTOM 8'h00

// Output-mode field codes
`define T0CO_COM_OFF 2'h0
`define T0CO_COM_TOGGLE 2'h1
`define T0CO_COM_CLEAR 2'h2
`define T0CO_COM_SET 2'h3

`endif

// ===== hdl/t0co_compare_output.v
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "t0co_consts.vh"

// What this block does
// [R1] Runs on the system clock; timer clock is a one-cycle enable only.
// [R2] Nonzero channel A output-mode field lets compare output A own its pin.
// [R3] Pin A driver is enabled only when its port direction bit is output.
// [R4] Non-PWM A: 00 off, 01 toggle, 10 clear, 11 set on match.
// [R5] PWM A with field 01: toggle on match if top-select set, else off.
// [R6] Fast PWM A: 10 clears on match, sets at BOTTOM; 11 the inverse.
// [R7] Fast PWM: compare equal TOP with upper bit set skips match, keeps BOTTOM.
// [R8] Phase correct A: 10 clears on up match, sets on down; 11 reverse.
// [R9] Phase correct: compare equal TOP with upper bit set acts at TOP.
// [R10] Nonzero channel B output-mode field lets compare output B own its pin.
// [R11] Pin B driver is enabled only when its port direction bit is output.
// [R12] Non-PWM B: 00 off, 01 toggle, 10 clear, 11 set on match.
// [R13] Fast PWM B: 01 reserved; 10 clears on match, sets at BOTTOM; 11 inverse.
// [R14] Phase correct B: 01 reserved; 10 clear up, set down; 11 reverse.
// [R15] Control bits 3 and 2 read zero and ignore writes.
// [R16] Waveform modes 0,1,2,3,5,7 decoded with their TOP; 4 and 6 reserved.
// [R17] MAX is 0xff and BOTTOM is 0x00.
// [R18] Fast PWM wraps TOP to BOTTOM on the next tick; BOTTOM action taken on the TOP tick.
// [R19] Compare outputs are flip-flops, reset to zero, updated only on ticks.
module t0co_compare_output #(
	parameter CNT_W = 8
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Counter side, same clock
	input wire timer_clock_enable,
	input wire [CNT_W-1:0] timer_count_value,
	input wire count_down,
	// Port logic, same clock
	input wire chan_a_port_dir,
	input wire chan_a_port_data,
	input wire chan_b_port_dir,
	input wire chan_b_port_data,
	// Pin drive
	output wire chan_a_pin_out,
	output wire chan_a_pin_oe,
	output wire chan_b_pin_out,
	output wire chan_b_pin_oe,
	// Compare output state
	output wire chan_a_compare_output,
	output wire chan_b_compare_output,
	output wire chan_a_override,
	output wire chan_b_override
);

	// Waveform classes
	localparam CLS_NONPWM = 2'd0;
	localparam CLS_FAST = 2'd1;
	localparam CLS_PC = 2'd2;
	localparam CLS_RSVD = 2'd3;

	// Software-visible registers, plus the active compare copies (cmp_act_reg) that reads never return
	reg [7:0] ctrl_reg;
	reg [7:0] aux_reg;
	reg [CNT_W-1:0] cmp_buf_reg [0:1];
	reg [CNT_W-1:0] cmp_act_reg [0:1];

	// Per-channel state, index 0 is channel A
	reg [1:0] oc_reg;
	reg [1:0] pin_out_reg;
	reg [1:0] pin_oe_reg;
	reg [1:0] override_reg;
	wire [1:0] oc_next;
	wire [1:0] connected;

	// Mode decode
	wire top_sel;
	wire [2:0] waveform_mode_select;
	reg [1:0] mode_cls;
	reg [CNT_W-1:0] top_value;
	wire at_top_tick;
	wire [1:0] port_dir_in;
	wire [1:0] port_data_in;
	wire [1:0] com [0:1];

	assign top_sel = aux_reg[`T0CO_AUX_TOPSEL];
	assign waveform_mode_select = {top_sel,
		ctrl_reg[`T0CO_WGM_HI:`T0CO_WGM_LO]};
	assign com[0] = ctrl_reg[`T0CO_COMA_HI:`T0CO_COMA_LO];
	assign com[1] = ctrl_reg[`T0CO_COMB_HI:`T0CO_COMB_LO];
	assign port_dir_in = {chan_b_port_dir, chan_a_port_dir};
	assign port_data_in = {chan_b_port_data, chan_a_port_data};

	// Class and TOP from the three-bit mode
	always @* begin
		mode_cls = CLS_RSVD; // see [R16]
		top_value = `T0CO_MAX; // see [R17]
		case (waveform_mode_select)
		`T0CO_WGM_NORMAL: begin
			mode_cls = CLS_NONPWM;
		end
		`T0CO_WGM_CTC: begin
			mode_cls = CLS_NONPWM;
			top_value = cmp_act_reg[0];
		end
		`T0CO_WGM_PC_FF: begin
			mode_cls = CLS_PC;
		end
		`T0CO_WGM_PC_A: begin
			mode_cls = CLS_PC;
			top_value = cmp_act_reg[0];
		end
		`T0CO_WGM_FAST_FF: begin
			mode_cls = CLS_FAST;
		end
		`T0CO_WGM_FAST_A: begin
			mode_cls = CLS_FAST;
			top_value = cmp_act_reg[0];
		end
		default: begin
			mode_cls = CLS_RSVD; // Reserved modes leave outputs alone
		end
		endcase
	end

	// Tick at TOP: fast PWM wraps to BOTTOM next, phase correct turns
	assign at_top_tick = timer_clock_enable &&
		(timer_count_value == top_value); // see [R1] [R18]

	// Register writes; bits 3:2 of control are never stored
	always @(posedge ref_clk) begin
		if (rst) begin
			ctrl_reg <= `T0CO_CTRL_RST;
			aux_reg <= `T0CO_AUX_RST;
			cmp_buf_reg[0] <= `T0CO_CMP_RST;
			cmp_buf_reg[1] <= `T0CO_CMP_RST;
		end else if (reg_wr) begin
			case (reg_addr)
			`T0CO_ADDR_CTRL: begin
				ctrl_reg <= reg_wdata & `T0CO_CTRL_WMASK; // see [R15]
			end
			`T0CO_ADDR_AUX: begin
				aux_reg <= {7'h00, reg_wdata[`T0CO_AUX_TOPSEL]};
			end
			`T0CO_ADDR_CMPA: begin
				cmp_buf_reg[0] <= reg_wdata[CNT_W-1:0];
			end
			`T0CO_ADDR_CMPB: begin
				cmp_buf_reg[1] <= reg_wdata[CNT_W-1:0];
			end
			default: begin
				ctrl_reg <= ctrl_reg;
			end
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`T0CO_ADDR_CTRL: reg_rdata <= ctrl_reg; // see [R15]
			`T0CO_ADDR_AUX: reg_rdata <= aux_reg;
			`T0CO_ADDR_CMPA: reg_rdata <= cmp_buf_reg[0];
			`T0CO_ADDR_CMPB: reg_rdata <= cmp_buf_reg[1];
			`T0CO_ADDR_STAT: begin
				reg_rdata <= {4'h0, override_reg, oc_reg};
			end
			default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_chan
			reg oc_n;
			reg conn;
			wire match_hit;
			wire at_top_cmp;
			wire is_chan_a;

			assign is_chan_a = (i == 0);
			assign match_hit = timer_clock_enable &&
				(timer_count_value == cmp_act_reg[i]);
			// Compare at TOP with the upper field bit set is special
			assign at_top_cmp = com[i][1] &&
				(cmp_act_reg[i] == top_value); // see [R7] [R9]

			// Compare value buffer: immediate outside PWM, else at TOP
			// so a new duty cycle never cuts a period short
			always @(posedge ref_clk) begin
				if (rst) begin
					cmp_act_reg[i] <= `T0CO_CMP_RST;
				end else if (mode_cls == CLS_NONPWM ||
					mode_cls == CLS_RSVD || at_top_tick) begin
					cmp_act_reg[i] <= cmp_buf_reg[i];
				end
			end

			// Pin ownership: field 01 in PWM is off unless A with top-select
			always @* begin
				conn = (com[i] != `T0CO_COM_OFF); // see [R2] [R10]
				if ((mode_cls == CLS_FAST || mode_cls == CLS_PC) &&
					com[i] == `T0CO_COM_TOGGLE) begin
					conn = is_chan_a && top_sel; // see [R5] [R13] [R14]
				end
			end

			// Next compare output value
			always @* begin
				oc_n = oc_reg[i];
				case (mode_cls)
				CLS_NONPWM: begin
					if (match_hit) begin
						case (com[i]) // see [R4] [R12]
						`T0CO_COM_TOGGLE: oc_n = ~oc_reg[i];
						`T0CO_COM_CLEAR: oc_n = 1'b0;
						`T0CO_COM_SET: oc_n = 1'b1;
						default: oc_n = oc_reg[i];
						endcase
					end
				end
				CLS_FAST: begin
					if (match_hit && !at_top_cmp) begin
						case (com[i]) // see [R6] [R13]
						`T0CO_COM_TOGGLE: oc_n = conn ? ~oc_reg[i] : oc_reg[i];
						`T0CO_COM_CLEAR: oc_n = 1'b0;
						`T0CO_COM_SET: oc_n = 1'b1;
						default: oc_n = oc_reg[i];
						endcase
					end
					// Wrap to BOTTOM: set for 10, clear for 11
					if (at_top_tick && com[i][1]) begin
						oc_n = ~com[i][0]; // see [R6] [R7] [R18]
					end
				end
				CLS_PC: begin
					if (at_top_cmp) begin
						// Match skipped; down-count result taken at TOP
						if (at_top_tick) begin
							oc_n = ~com[i][0]; // see [R9]
						end
					end else if (match_hit) begin
						case (com[i]) // see [R5] [R8] [R14]
						`T0CO_COM_TOGGLE: oc_n = conn ? ~oc_reg[i] : oc_reg[i];
						`T0CO_COM_CLEAR: oc_n = count_down;
						`T0CO_COM_SET: oc_n = ~count_down;
						default: oc_n = oc_reg[i];
						endcase
					end
				end
				default: begin
					oc_n = oc_reg[i];
				end
				endcase
			end

			assign oc_next[i] = oc_n;
			assign connected[i] = conn;

			// Output flip-flop moves only on a timer tick
			always @(posedge ref_clk) begin
				if (rst) begin
					oc_reg[i] <= 1'b0; // see [R19]
				end else if (timer_clock_enable) begin
					oc_reg[i] <= oc_next[i]; // see [R1] [R19]
				end
			end

			// Pin mux; the direction bit alone enables the driver
			always @(posedge ref_clk) begin
				if (rst) begin
					pin_out_reg[i] <= 1'b0;
					pin_oe_reg[i] <= 1'b0;
					override_reg[i] <= 1'b0;
				end else begin
					override_reg[i] <= connected[i];
					pin_out_reg[i] <= connected[i] ?
						oc_next[i] : port_data_in[i];
					pin_oe_reg[i] <= port_dir_in[i]; // see [R3] [R11]
				end
			end
		end
	endgenerate

	// Outputs straight from flip-flops
	assign chan_a_pin_out = pin_out_reg[0];
	assign chan_a_pin_oe = pin_oe_reg[0];
	assign chan_b_pin_out = pin_out_reg[1];
	assign chan_b_pin_oe = pin_oe_reg[1];
	assign chan_a_compare_output = oc_reg[0];
	assign chan_b_compare_output = oc_reg[1];
	assign chan_a_override = override_reg[0];
	assign chan_b_override = override_reg[1];

endmodule

// ===== verification/t0co_compare_output_properties.sv
`timescale 1ns/100ps
module t0co_compare_output_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Timer and pins
	input wire logic timer_clock_enable,
	input wire logic chan_a_port_dir,
	input wire logic chan_b_port_dir,
	input wire logic chan_a_pin_out,
	input wire logic chan_a_pin_oe,
	input wire logic chan_b_pin_out,
	input wire logic chan_b_pin_oe,
	input wire logic chan_a_compare_output,
	input wire logic chan_b_compare_output,
	input wire logic chan_a_override,
	input wire logic chan_b_override
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Compare output flops only move on a timer tick
	AST_A_HOLD: assert property (!timer_clock_enable |=>
		$stable(chan_a_compare_output)) else $error("A moved untimed");
	AST_B_HOLD: assert property (!timer_clock_enable |=>
		$stable(chan_b_compare_output)) else $error("B moved untimed");
	// Driver enable trails direction bit by one cycle
	AST_A_OE: assert property (1 |=>
		chan_a_pin_oe == $past(chan_a_port_dir)) else $error("A oe");
	AST_B_OE: assert property (1 |=>
		chan_b_pin_oe == $past(chan_b_port_dir)) else $error("B oe");
	AST_A_PIN: assert property (chan_a_override |->
		chan_a_pin_out == chan_a_compare_output) else $error("A pin");
	AST_B_PIN: assert property (chan_b_override |->
		chan_b_pin_out == chan_b_compare_output) else $error("B pin");
	AST_RSV_BITS: assert property (reg_rd && reg_addr == 8'h1b |=>
		reg_rdata[3:2] == 2'b00) else $error("reserved bits set");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside slot");
	AST_RST_ZERO: assert property ($fell(rst) |->
		!chan_a_compare_output && !chan_b_compare_output)
		else $error("outputs not cleared by reset");
endmodule
bind t0co_compare_output t0co_compare_output_properties u_props (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .timer_clock_enable(timer_clock_enable),
	.chan_a_port_dir(chan_a_port_dir), .chan_b_port_dir(chan_b_port_dir),
	.chan_a_pin_out(chan_a_pin_out), .chan_a_pin_oe(chan_a_pin_oe),
	.chan_b_pin_out(chan_b_pin_out), .chan_b_pin_oe(chan_b_pin_oe),
	.chan_a_compare_output(chan_a_compare_output),
	.chan_b_compare_output(chan_b_compare_output),
	.chan_a_override(chan_a_override), .chan_b_override(chan_b_override));

// ===== verification/t0co_pin_load.sv
`timescale 1ns/100ps
module t0co_pin_load (
	// Pin drive from the block
	input wire logic pin_out,
	input wire logic pin_oe,
	// Level seen on the wire
	output wire logic pin_level
);
	// Pull-up load, so an undriven pin always reads high, whatever value was last driven
	assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("Error at %0t got %0h exp %0h", $time, (g), (e)); \
	end \
end
module testbench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic timer_clock_enable = 1'b0;
	logic [7:0] timer_count_value = 8'h00;
	logic count_down = 1'b0;
	logic a_dir = 1'b0;
	logic a_data = 1'b0;
	logic b_dir = 1'b0;
	logic b_data = 1'b0;
	logic a_out, a_oe, b_out, b_oe, a_cmp, b_cmp, a_ovr, b_ovr;
	logic a_level, b_level, prev_a;
	int mismatches = 0;
	int samples_checked = 0;
	// Rows: ctrl, both compares, count, down in bit 4, expected in bit 0
	logic [31:0] steps [17] = '{32'hf0101001, 32'ha0101000, 32'h50101001,
		32'h50111001, 32'h50101000, 32'ha310ff01, 32'ha3101000,
		32'hf310ff00, 32'hf3101001, 32'ha1101000, 32'ha1101011,
		32'hf1101001, 32'hf1101010, 32'ha3ffff01, 32'ha3ffff01,
		32'hf1ffff00, 32'hf1ffff00};

	t0co_compare_output u_dut (.ref_clk(ref_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_clock_enable(timer_clock_enable),
		.timer_count_value(timer_count_value), .count_down(count_down),
		.chan_a_port_dir(a_dir), .chan_a_port_data(a_data),
		.chan_b_port_dir(b_dir), .chan_b_port_data(b_data),
		.chan_a_pin_out(a_out), .chan_a_pin_oe(a_oe),
		.chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe),
		.chan_a_compare_output(a_cmp), .chan_b_compare_output(b_cmp),
		.chan_a_override(a_ovr), .chan_b_override(b_ovr));
	t0co_pin_load u_load_a (.pin_out(a_out), .pin_oe(a_oe),
		.pin_level(a_level));
	t0co_pin_load u_load_b (.pin_out(b_out), .pin_oe(b_oe),
		.pin_level(b_level));

	// Free-running system clock
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic close_out;
		$display("mismatches %0d samples_checked %0d", mismatches,
			samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data only stands in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask

	// One timer tick, outputs settle at the tick edge
	task automatic tick(input logic [7:0] c, input logic d);
		@(posedge ref_clk);
		timer_clock_enable <= 1'b1;
		timer_count_value <= c;
		count_down <= d;
		@(posedge ref_clk);
		timer_clock_enable <= 1'b0;
		#1;
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rd_chk(8'h1b, 8'h00);
		rd_chk(8'h40, 8'h00);
		wr(8'h1b, 8'hff);
		rd_chk(8'h1b, 8'hf3);
		wr(8'h1b, 8'h00);
		@(posedge ref_clk);
		a_data <= 1'b1;
		tick(8'h10, 1'b0);
		`CHK(a_ovr, 1'b0)
		`CHK(a_out, 1'b1)
		`CHK(a_level, 1'b1)
		@(posedge ref_clk);
		a_dir <= 1'b1;
		b_dir <= 1'b1;
		tick(8'h10, 1'b0);
		`CHK(a_oe, 1'b1)
		`CHK(b_oe, 1'b1)
		foreach (steps[i]) begin
			wr(8'h1b, steps[i][31:24]);
			wr(8'h1d, steps[i][23:16]);
			wr(8'h1e, steps[i][23:16]);
			tick(steps[i][15:8], steps[i][4]);
			`CHK(a_cmp, steps[i][0])
			`CHK(b_cmp, steps[i][0])
			`CHK(b_ovr, 1'b1)
			`CHK(a_level, steps[i][0])
			`CHK(b_level, steps[i][0])
		end
		// Toggle in fast PWM hinges on the top-select bit
		wr(8'h1b, 8'h43);
		wr(8'h1c, 8'h00);
		tick(8'hff, 1'b0);
		`CHK(a_ovr, 1'b0)
		wr(8'h1c, 8'h01);
		prev_a = a_cmp;
		tick(8'hff, 1'b0);
		`CHK(a_cmp, ~prev_a)
		`CHK(a_ovr, 1'b1)
		// Status: A owns its pin and is high, B idle and low
		rd_chk(8'h1f, 8'h05);
		rd_chk(8'h1c, 8'h01);
		rd_chk(8'h1d, 8'hff);
		// Reserved mode 4 holds the output even on a match
		wr(8'h1b, 8'hf0);
		prev_a = a_cmp;
		tick(8'hff, 1'b0);
		`CHK(a_cmp, prev_a)
		`CHK(a_ovr, 1'b1)
		close_out();
	end

	// Cut a hang short well past the expected run length
	initial begin
		#100000;
		mismatches++;
		close_out();
	end
endmodule
